// ==== isa_pkg.sv ====
/*
 * Shared constants and types of the I2C target address/receive block.
 * Assumes both the core clock domain and the link clock domain use it.
 */
package isa_pkg;

	// ------------------------------------------------------------------
	// Mode select codes (port_mode_select)
	// ------------------------------------------------------------------
	localparam logic [3:0] MODE_7BIT       = 4'h6;
	localparam logic [3:0] MODE_10BIT      = 4'h7;
	localparam logic [3:0] MODE_7BIT_SP    = 4'he;
	localparam logic [3:0] MODE_10BIT_SP   = 4'hf;
	localparam int         MODE_TEN_POS    = 0;
	localparam int         MODE_SPIRQ_POS  = 3;

	// ------------------------------------------------------------------
	// Protocol constants
	// ------------------------------------------------------------------
	localparam logic [4:0] TEN_HI_PREFIX   = 5'h1e;
	localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
	localparam int         SYNC_STAGES     = 2;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] OWN_ADDR_RST    = 8'h00;
	localparam logic [7:0] BUF_RST         = 8'h00;
	localparam logic       CKP_RST         = 1'b1;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		EK_ADDR = 2'b00,
		EK_LOW  = 2'b01,
		EK_DATA = 2'b10
	} isa_kind_t;

	typedef enum logic [1:0] {
		LS_IDLE    = 2'b00,
		LS_RECV    = 2'b01,
		LS_ACK     = 2'b10,
		LS_STRETCH = 2'b11
	} isa_lstate_t;

	// Byte event handed from the link domain to the core domain
	typedef struct packed {
		isa_kind_t  kind;
		logic       acked;
		logic       hit;
		logic [7:0] data;
	} isa_evt_t;

	// Quasi-static settings passed from the core domain to the link
	typedef struct packed {
		logic [3:0] mode;
		logic       stretchEn;
		logic       overwriteEn;
		logic       busy;
	} isa_cfg_t;

endpackage

// ==== isa_pulse_sync.sv ====
/*
 * Toggle-to-pulse crossing: a toggle from another clock passes two
 * flip-flops, then a third stage finds its edge and gives a one-cycle
 * pulse. Assumes the source toggles no faster than every three cycles.
 */
`timescale 1ns/1ps
module isa_pulse_sync (
	input  wire logic dstClk,
	input  wire logic nrst,
	input  wire logic togIn,
	output logic      pulse
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge dstClk or negedge nrst) begin
		if (!nrst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= togIn;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign pulse = s2_r ^ s3_r;
endmodule // isa_pulse_sync

// ==== isa_target.sv ====
/*
 * I2C target: own-address matching (7 and 10 bit), byte reception with
 * ACK/NACK, overflow, clock stretching and start/stop detection.
 * Assumes open-drain pins resolved outside; linkClk samples the bus and
 * is much faster than SCL. Software side is plain pulses and levels.
 */
// Contract
// [RULE1] Four modes via mode select: 7-bit or 10-bit, with or without S/P irq.
// [RULE2] Start/stop interrupt modes also flag on Start, Restart and Stop.
// [RULE3] First byte after Start compared to own address; match loads, flags.
// [RULE4] Mismatch on first byte: go idle silently, no flag.
// [RULE5] 7-bit match ignores the direction bit.
// [RULE6] 10-bit first byte compared to 11110,A9,A8,0 from own address bits 2:1.
// [RULE7] After acking 10-bit high byte: set update flag, hold SCL.
// [RULE8] Low byte: compare eight bits; always flag, update flag, stretch.
// [RULE9] Writing own address clears the update flag.
// [RULE10] Controller starts 10-bit with write match, reads via Restart.
// [RULE11] 10-bit read acked only after a full high+low match.
// [RULE12] Matching write address clears direction bit, loads buffer, acks.
// [RULE13] Buffer full or overflow gives NACK unless overwrite enabled.
// [RULE14] Every byte sets irq flag; only software clears it.
// [RULE15] Stretch enable holds SCL after each byte until clock release.
// [RULE16] Start sets start-seen; irq too when start irq enabled.
// [RULE17] Reading the shift buffer clears buffer full.
// [RULE18] Each data byte acked with SDA low and flags irq.
// [RULE19] Stop sets stop-seen and returns to idle.
// [RULE20] Controller clocks data after release until it sends Stop.
// [RULE21] NACK leaves SDA released during the ack clock.
`timescale 1ns/1ps
module isa_target (
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic       linkClk,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sclOut,
	output logic            sclOe,
	output logic            sdaOut,
	output logic            sdaOe,
	input  wire logic [3:0] portModeSelect,
	input  wire logic       stretchEnable,
	input  wire logic       bufferOverwriteEnable,
	input  wire logic       ownAddrWr,
	input  wire logic [7:0] ownAddrIn,
	input  wire logic       shiftBufRd,
	input  wire logic       irqFlagClr,
	input  wire logic       overflowClr,
	input  wire logic       clockReleaseSet,
	output logic [7:0]      ownAddressReg,
	output logic [7:0]      shiftBufferReg,
	output logic            portIrqFlag,
	output logic            bufferFullFlag,
	output logic            receiveOverflowFlag,
	output logic            addressUpdateFlag,
	output logic            clockReleaseBit,
	output logic            readWriteBit,
	output logic            startSeen,
	output logic            stopSeen
);
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic addrHit(input logic [7:0] rx,
		input logic [7:0] own, input logic ten);
		if (ten)
			addrHit = (rx[7:1] == {isa_pkg::TEN_HI_PREFIX, own[2:1]});
		else
			addrHit = (rx[7:1] == own[7:1]);
	endfunction

	function automatic logic modeValid(input logic [3:0] m);
		modeValid = (m == isa_pkg::MODE_7BIT) || (m == isa_pkg::MODE_10BIT)
			|| (m == isa_pkg::MODE_7BIT_SP) || (m == isa_pkg::MODE_10BIT_SP);
	endfunction

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	isa_pkg::isa_cfg_t    cfgCore;
	isa_pkg::isa_cfg_t    cfgSync_r [isa_pkg::SYNC_STAGES];
	isa_pkg::isa_cfg_t    cfgL;
	isa_pkg::isa_evt_t    evt_r;
	isa_pkg::isa_lstate_t lState_r;
	isa_pkg::isa_kind_t   kind_r;
	logic [1:0] sclSync_r;
	logic [1:0] sdaSync_r;
	logic       sclP_r;
	logic       sdaP_r;
	logic       sclS;
	logic       sdaS;
	logic       startDet;
	logic       stopDet;
	logic       sclRise;
	logic       sclFall;
	logic [3:0] bitCnt_r;
	logic [7:0] shReg_r;
	logic [7:0] ownL_r;
	logic       matched10_r;
	logic       rdAddr_r;
	logic       uaHold_r;
	logic       acked_r;
	logic       evtTog_r;
	logic       startTog_r;
	logic       stopTog_r;
	logic       addrTog_r;
	logic       clkTog_r;
	logic       addrPend_r;
	logic       clkPend_r;
	logic       addrPulseL;
	logic       clkPulseL;
	logic       evtPulse;
	logic       startPulse;
	logic       stopPulse;
	logic       tenBit;
	logic       spIrq;
	logic       byteDone;
	logic       ackNow;
	logic       hitNow;
	logic       okLoad;
	logic       needStretch;
	logic       resume;
	logic       released;

	// ------------------------------------------------------------------
	// Crossings
	// ------------------------------------------------------------------
	isa_pulse_sync uEvt (.dstClk(core_clk), .nrst(nrst), .togIn(evtTog_r),
		.pulse(evtPulse));
	isa_pulse_sync uStart (.dstClk(core_clk), .nrst(nrst),
		.togIn(startTog_r), .pulse(startPulse));
	isa_pulse_sync uStop (.dstClk(core_clk), .nrst(nrst), .togIn(stopTog_r),
		.pulse(stopPulse));
	isa_pulse_sync uAddr (.dstClk(linkClk), .nrst(nrst), .togIn(addrTog_r),
		.pulse(addrPulseL));
	isa_pulse_sync uClk (.dstClk(linkClk), .nrst(nrst), .togIn(clkTog_r),
		.pulse(clkPulseL));

	assign cfgCore = '{mode: portModeSelect, stretchEn: stretchEnable,
		overwriteEn: bufferOverwriteEnable,
		busy: bufferFullFlag | receiveOverflowFlag};

	// Settings are static during a byte; per-bit sync is adequate
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			cfgSync_r[0] <= '0;
			cfgSync_r[1] <= '0;
		end else begin
			cfgSync_r[0] <= cfgCore;
			cfgSync_r[1] <= cfgSync_r[0];
		end
	end
	assign cfgL   = cfgSync_r[1];
	assign tenBit = cfgL.mode[isa_pkg::MODE_TEN_POS];             // [RULE1]

	// ------------------------------------------------------------------
	// Link domain: pin sampling and condition detection
	// ------------------------------------------------------------------
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			sclSync_r <= 2'h3;
			sdaSync_r <= 2'h3;
			sclP_r    <= 1'b1;
			sdaP_r    <= 1'b1;
		end else begin
			sclSync_r <= {sclSync_r[0], sclIn};
			sdaSync_r <= {sdaSync_r[0], sdaIn};
			sclP_r    <= sclSync_r[1];
			sdaP_r    <= sdaSync_r[1];
		end
	end
	assign sclS     = sclSync_r[1];
	assign sdaS     = sdaSync_r[1];
	assign startDet = sclS & sclP_r & sdaP_r & ~sdaS & modeValid(cfgL.mode);
	assign stopDet  = sclS & sclP_r & ~sdaP_r & sdaS;
	assign sclRise  = sclS & ~sclP_r;
	assign sclFall  = ~sclS & sclP_r;
	assign byteDone = (lState_r == isa_pkg::LS_RECV) && sclFall
		&& (bitCnt_r == isa_pkg::BITS_PER_BYTE);
	assign okLoad   = ~cfgL.busy | cfgL.overwriteEn;              // [RULE13]

	// Address decision on the completed byte
	always_comb begin
		hitNow = 1'b1;
		ackNow = okLoad;
		unique case (kind_r)
			isa_pkg::EK_ADDR: begin
				hitNow = addrHit(shReg_r, ownL_r, tenBit);  // [RULE5] [RULE6]
				if (tenBit && shReg_r[0] && !matched10_r)
					hitNow = 1'b0;                             // [RULE11]
				ackNow = hitNow & okLoad;
			end
			isa_pkg::EK_LOW: begin
				hitNow = (shReg_r == ownL_r);                  // [RULE8]
				ackNow = hitNow & okLoad;
			end
			isa_pkg::EK_DATA: ;
		endcase
	end

	// ------------------------------------------------------------------
	// Link domain: release requests from software
	// ------------------------------------------------------------------
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			ownL_r     <= isa_pkg::OWN_ADDR_RST;
			addrPend_r <= 1'b0;
			clkPend_r  <= 1'b0;
		end else begin
			if (addrPulseL)
				ownL_r <= ownAddressReg;
			// Latched so a reply before the stretch begins is not lost
			addrPend_r <= addrPulseL | (addrPend_r & ~byteDone);
			clkPend_r  <= clkPulseL | (clkPend_r & ~byteDone);
		end
	end
	assign released = uaHold_r ? addrPend_r : clkPend_r;
	assign resume   = acked_r & ~rdAddr_r;
	assign needStretch = uaHold_r | cfgL.stretchEn | (rdAddr_r & acked_r);

	// ------------------------------------------------------------------
	// Link domain: receive state machine
	// ------------------------------------------------------------------
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			lState_r    <= isa_pkg::LS_IDLE;
			kind_r      <= isa_pkg::EK_ADDR;
			bitCnt_r    <= 4'h0;
			shReg_r     <= 8'h00;
			matched10_r <= 1'b0;
			rdAddr_r    <= 1'b0;
			uaHold_r    <= 1'b0;
			acked_r     <= 1'b0;
			sdaOe       <= 1'b0;
			sclOe       <= 1'b0;
		end else if (stopDet) begin
			lState_r    <= isa_pkg::LS_IDLE;                   // [RULE19]
			matched10_r <= 1'b0;
			sdaOe       <= 1'b0;
			sclOe       <= 1'b0;
		end else if (startDet) begin
			lState_r <= isa_pkg::LS_RECV;                      // [RULE3]
			kind_r   <= isa_pkg::EK_ADDR;
			bitCnt_r <= 4'h0;
			sdaOe    <= 1'b0;
		end else begin
			unique case (lState_r)
				isa_pkg::LS_IDLE: ;
				isa_pkg::LS_RECV: begin
					if (sclRise) begin
						shReg_r  <= {shReg_r[6:0], sdaS};
						bitCnt_r <= bitCnt_r + 4'h1;
					end
					if (byteDone) begin
						bitCnt_r <= 4'h0;
						acked_r  <= ackNow;
						if (kind_r == isa_pkg::EK_ADDR) begin
							rdAddr_r <= shReg_r[0];
							// No hold after a refused high byte
							uaHold_r <= tenBit & ~shReg_r[0] & ackNow; // [RULE7]
							kind_r   <= (tenBit && !shReg_r[0])
								? isa_pkg::EK_LOW : isa_pkg::EK_DATA;
						end else if (kind_r == isa_pkg::EK_LOW) begin
							uaHold_r    <= 1'b1;                   // [RULE8]
							matched10_r <= hitNow;
							kind_r      <= isa_pkg::EK_DATA;
						end else begin
							uaHold_r <= 1'b0;
						end
						if (!hitNow)
							lState_r <= (kind_r == isa_pkg::EK_ADDR)
								? isa_pkg::LS_IDLE : isa_pkg::LS_ACK;  // [RULE4]
						else
							lState_r <= isa_pkg::LS_ACK;
						sdaOe <= ackNow;                   // [RULE18] [RULE21]
					end
				end
				isa_pkg::LS_ACK: begin
					if (sclFall) begin
						sdaOe <= 1'b0;
						if (needStretch) begin
							sclOe    <= 1'b1;                  // [RULE15] [RULE7]
							lState_r <= isa_pkg::LS_STRETCH;
						end else begin
							lState_r <= resume ? isa_pkg::LS_RECV
								: isa_pkg::LS_IDLE;
						end
					end
				end
				isa_pkg::LS_STRETCH: begin
					if (released) begin
						sclOe    <= 1'b0;
						uaHold_r <= 1'b0;
						lState_r <= resume ? isa_pkg::LS_RECV
							: isa_pkg::LS_IDLE;
					end
				end
			endcase
		end
	end

	// Byte and condition events toward the core domain
	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			evt_r      <= '0;
			evtTog_r   <= 1'b0;
			startTog_r <= 1'b0;
			stopTog_r  <= 1'b0;
			sclOut     <= 1'b0;
			sdaOut     <= 1'b0;
		end else begin
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
			if (startDet)
				startTog_r <= ~startTog_r;
			if (stopDet)
				stopTog_r <= ~stopTog_r;
			if (!stopDet && !startDet && byteDone
				&& (hitNow || kind_r != isa_pkg::EK_ADDR)) begin
				evt_r    <= '{kind: kind_r, acked: ackNow, hit: hitNow,
					data: shReg_r};
				evtTog_r <= ~evtTog_r;
			end
		end
	end

	// ------------------------------------------------------------------
	// Core domain: software-visible state
	// ------------------------------------------------------------------
	assign spIrq = cfgCore.mode[isa_pkg::MODE_SPIRQ_POS];

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ownAddressReg     <= isa_pkg::OWN_ADDR_RST;
			addressUpdateFlag <= 1'b0;
			addrTog_r         <= 1'b0;
		end else begin
			if (ownAddrWr) begin
				ownAddressReg <= ownAddrIn;
				addrTog_r     <= ~addrTog_r;
			end
			if (evtPulse && (evt_r.kind == isa_pkg::EK_LOW
				|| (evt_r.kind == isa_pkg::EK_ADDR && evt_r.acked
				&& cfgCore.mode[isa_pkg::MODE_TEN_POS] && !evt_r.data[0])))
				addressUpdateFlag <= 1'b1;                     // [RULE7] [RULE8]
			else if (ownAddrWr)
				addressUpdateFlag <= 1'b0;                     // [RULE9]
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			portIrqFlag <= 1'b0;
			startSeen   <= 1'b0;
			stopSeen    <= 1'b0;
		end else begin
			if (evtPulse || ((startPulse || stopPulse) && spIrq))
				portIrqFlag <= 1'b1;                   // [RULE14] [RULE2] [RULE16]
			else if (irqFlagClr)
				portIrqFlag <= 1'b0;
			if (startPulse) begin
				startSeen <= 1'b1;                             // [RULE16]
				stopSeen  <= 1'b0;
			end else if (stopPulse) begin
				stopSeen  <= 1'b1;                             // [RULE19]
				startSeen <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			shiftBufferReg      <= isa_pkg::BUF_RST;
			bufferFullFlag      <= 1'b0;
			receiveOverflowFlag <= 1'b0;
			readWriteBit        <= 1'b0;
		end else begin
			if (evtPulse && evt_r.kind == isa_pkg::EK_ADDR)
				readWriteBit <= evt_r.data[0];                 // [RULE12]
			if (evtPulse && evt_r.hit && evt_r.acked) begin
				shiftBufferReg <= evt_r.data;              // [RULE3] [RULE12]
				bufferFullFlag <= 1'b1;
			end else if (shiftBufRd) begin
				bufferFullFlag <= 1'b0;                        // [RULE17]
			end
			if (evtPulse && evt_r.hit && bufferFullFlag)
				receiveOverflowFlag <= 1'b1;                   // [RULE13]
			else if (overflowClr)
				receiveOverflowFlag <= 1'b0;
		end
	end

	// Clock release bit; cleared by hardware on a byte event with stretch enabled or on an acked read address
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			clockReleaseBit <= isa_pkg::CKP_RST;
			clkTog_r        <= 1'b0;
		end else begin
			if (evtPulse && (stretchEnable
				|| (evt_r.kind == isa_pkg::EK_ADDR && evt_r.data[0]
				&& evt_r.acked)))
				clockReleaseBit <= 1'b0;                       // [RULE15]
			else if (clockReleaseSet)
				clockReleaseBit <= 1'b1;
			if (clockReleaseSet)
				clkTog_r <= ~clkTog_r;
		end
	end
endmodule // isa_target

// ==== isa_checker.sv ====
/*
 * Checker of the I2C target: software pulses against flags and the
 * open-drain enables. Assumes it is bound to isa_target, ports only.
 */
`timescale 1ns/1ps
module isa_checker (
	input wire logic       core_clk,
	input wire logic       nrst,
	input wire logic       linkClk,
	input wire logic       sclIn,
	input wire logic       sclOe,
	input wire logic       sdaOe,
	input wire logic       stretchEnable,
	input wire logic       ownAddrWr,
	input wire logic [7:0] ownAddrIn,
	input wire logic       shiftBufRd,
	input wire logic       irqFlagClr,
	input wire logic       clockReleaseSet,
	input wire logic [7:0] ownAddressReg,
	input wire logic       portIrqFlag,
	input wire logic       bufferFullFlag,
	input wire logic       addressUpdateFlag,
	input wire logic       clockReleaseBit
);
	// ------------------------------------------------------------
	// Core and link domain relations
	// ------------------------------------------------------------
	irq_sw_clear_a:
	assert property (@(posedge core_clk) disable iff (!nrst)
		$fell(portIrqFlag) |-> $past(irqFlagClr))
	else $error("irq flag fell without a clear");
	addr_write_a:
	assert property (@(posedge core_clk) disable iff (!nrst) ownAddrWr |=>
		ownAddressReg == $past(ownAddrIn) && !addressUpdateFlag)
	else $error("address write not taken");
	full_clear_a:
	assert property (@(posedge core_clk) disable iff (!nrst)
		shiftBufRd |=> !bufferFullFlag)
	else $error("buffer read left full flag");
	ckp_set_a:
	assert property (@(posedge core_clk) disable iff (!nrst)
		clockReleaseSet |=> clockReleaseBit)
	else $error("release bit not set");
	ckp_release_a:
	assert property (@(posedge core_clk) disable iff (!nrst)
		clockReleaseSet && sclOe && !addressUpdateFlag |-> ##[1:12] !sclOe)
	else $error("clock not released");
	ua_release_a:
	assert property (@(posedge core_clk) disable iff (!nrst)
		ownAddrWr && addressUpdateFlag && sclOe && !stretchEnable
		|-> ##[1:12] !sclOe)
	else $error("address update did not release clock");
	ack_edge_a:
	assert property (@(posedge linkClk) disable iff (!nrst)
		$changed(sdaOe) |-> !sclIn)
	else $error("data line moved while clock high");
	stretch_start_a:
	assert property (@(posedge linkClk) disable iff (!nrst)
		$rose(sclOe) |-> !$past(sclIn))
	else $error("stretch began in a high phase");
endmodule // isa_checker

bind isa_target isa_checker u_isa_checker (.*);

// ==== isa_i2c_ctrl.sv ====
/*
 * Behavioural I2C bus controller: start, restart, stop and byte writes
 * returning the acknowledge. Assumes pull-ups resolve both lines.
 */
`timescale 1ns/1ps
module isa_i2c_ctrl #(
	parameter int Q = 100
) (
	input  wire logic scl,
	input  wire logic sda,
	output logic      sclLow,
	output logic      sdaLow
);
	initial begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
	end
	// A stretched clock delays the high phase, never shortens it
	task automatic hi();
		sclLow = 1'b0;
		wait (scl === 1'b1);
		#Q;
	endtask
	task automatic start();
		sdaLow = 1'b0;
		#Q;
		hi();
		sdaLow = 1'b1;
		#Q;
		sclLow = 1'b1;
		#Q;
	endtask
	task automatic stop();
		sdaLow = 1'b1;
		#Q;
		hi();
		sdaLow = 1'b0;
		#Q;
	endtask
	task automatic xfer(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sdaLow = !b[i];
			#Q;
			hi();
			sclLow = 1'b1;
			#Q;
		end
		sdaLow = 1'b0;
		#Q;
		hi();
		ack = !sda;
		sclLow = 1'b1;
		#Q;
	endtask
endmodule // isa_i2c_ctrl

// ==== tb.sv ====
/*
 * Bench of the I2C target: software pulses, a bus controller model on
 * the pins, self-checks. Assumes the checker is bound to the design.
 */
`timescale 1ns/1ps
module tb;
	localparam logic [4:0] WR = 5'h10, RD = 5'h08, CL = 5'h04, OV = 5'h02;
	localparam logic [4:0] RL = 5'h01;
	logic       core_clk = 1'b0, linkClk = 1'b0, nrst = 1'b0, ack;
	logic       stretchEnable = 1'b0, bufferOverwriteEnable = 1'b0;
	logic [4:0] pls = 5'h00;
	logic [3:0] portModeSelect = isa_pkg::MODE_7BIT;
	logic [7:0] ownAddrIn = 8'h00, ownAddressReg, shiftBufferReg, d, hb, lo;
	logic       sclLow, sdaLow, sclOut, sclOe, sdaOut, sdaOe, startSeen;
	logic       portIrqFlag, bufferFullFlag, receiveOverflowFlag, stopSeen;
	logic       addressUpdateFlag, clockReleaseBit, readWriteBit;
	int         mismatches = 0, checks_done = 0, seed = 45168;
	wire        ownAddrWr = pls[4], shiftBufRd = pls[3], irqFlagClr = pls[2];
	wire        overflowClr = pls[1], clockReleaseSet = pls[0];
	wire        sclIn = !(sclLow | sclOe);
	wire        sdaIn = !(sdaLow | sdaOe);
	always #5 core_clk = !core_clk;
	// Odd offset keeps link edges apart from core edges
	initial begin
		#1.7;
		forever #3 linkClk = !linkClk;
	end
	isa_target u_isa_target (.*);
	isa_i2c_ctrl u_isa_i2c_ctrl (.scl(sclIn), .sda(sdaIn), .sclLow(sclLow),
		.sdaLow(sdaLow));
	task automatic chk(input string n, input logic [7:0] e, s);
		@(negedge core_clk);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic chk1(input string n, input logic e, s);
		chk(n, 8'(e), 8'(s));
	endtask
	task automatic sw(input logic [4:0] p, input logic [7:0] v);
		@(posedge core_clk);
		pls <= p;
		ownAddrIn <= v;
		@(posedge core_clk);
		pls <= 5'h00;
		repeat (4) @(posedge core_clk);
	endtask
	// Settings only change while the bus is idle
	task automatic cfg(input logic [3:0] m, input logic se, ow);
		@(posedge core_clk);
		portModeSelect <= m;
		stretchEnable <= se;
		bufferOverwriteEnable <= ow;
		repeat (8) @(posedge core_clk);
	endtask
	task automatic frame(input logic [7:0] b, input logic ea);
		u_isa_i2c_ctrl.start();
		u_isa_i2c_ctrl.xfer(b, ack);
		chk1("ack", ea, ack);
	endtask
	function automatic logic [7:0] hiByte(input logic [7:0] own);
		return {isa_pkg::TEN_HI_PREFIX, own[2:1], 1'b0};
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// About twenty bytes of 2.7 us each; the margin is generous
	initial begin
		#400000;
		mismatches++;
		wrap_up();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		sw(WR, 8'hff);
		frame(8'h5a, 1'b0);
		chk1("irq", 1'b0, portIrqFlag);
		u_isa_i2c_ctrl.stop();
		frame(8'hfe, 1'b1);
		chk("abuf", 8'hfe, shiftBufferReg);
		chk1("rw", 1'b0, readWriteBit);
		chk1("s", 1'b1, startSeen);
		sw(RD | CL, 8'h00);
		chk1("bf", 1'b0, bufferFullFlag);
		for (int i = 0; i < 4; i++) begin
			d = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($random(seed));
			u_isa_i2c_ctrl.xfer(d, ack);
			chk1("dack", 1'b1, ack);
			chk("dbuf", d, shiftBufferReg);
			repeat (40) @(posedge core_clk);
			chk1("irq", 1'b1, portIrqFlag);
			sw(RD | CL, 8'h00);
		end
		u_isa_i2c_ctrl.stop();
		chk1("p", 1'b1, stopSeen);
		$display("test receive done");
		frame(8'hfe, 1'b1);
		u_isa_i2c_ctrl.stop();
		frame(8'hfe, 1'b0);
		chk1("ov", 1'b1, receiveOverflowFlag);
		u_isa_i2c_ctrl.stop();
		cfg(isa_pkg::MODE_7BIT, 1'b0, 1'b1);
		frame(8'hfe, 1'b1);
		u_isa_i2c_ctrl.stop();
		sw(RD | CL | OV, 8'h00);
		$display("test overflow done");
		cfg(4'h0, 1'b0, 1'b0);
		frame(8'hfe, 1'b0);
		chk1("off", 1'b0, startSeen);
		u_isa_i2c_ctrl.stop();
		cfg(isa_pkg::MODE_7BIT_SP, 1'b1, 1'b0);
		u_isa_i2c_ctrl.start();
		chk1("sirq", 1'b1, portIrqFlag);
		sw(CL, 8'h00);
		u_isa_i2c_ctrl.xfer(8'hfe, ack);
		for (int i = 0; i < 2; i++) begin
			repeat (50) @(posedge core_clk);
			chk1("hold", 1'b1, sclOe);
			chk1("ckp", 1'b0, clockReleaseBit);
			sw(RL | RD | CL, 8'h00);
			if (i == 0)
				u_isa_i2c_ctrl.xfer(8'($random(seed)), ack);
		end
		u_isa_i2c_ctrl.stop();
		chk1("pirq", 1'b1, portIrqFlag);
		$display("test stretch done");
		cfg(isa_pkg::MODE_10BIT, 1'b0, 1'b0);
		d = 8'($random(seed));
		hb = hiByte(d);
		sw(WR | CL, d);
		frame(hb | 8'h01, 1'b0);
		chk1("nirq", 1'b0, portIrqFlag);
		u_isa_i2c_ctrl.stop();
		// Write match first, read only after a restart
		frame(hb, 1'b1);
		repeat (50) @(posedge core_clk);
		chk1("ua", 1'b1, addressUpdateFlag);
		chk1("uas", 1'b1, sclOe);
		lo = 8'($random(seed));
		sw(WR | CL | RD, lo);
		chk1("uac", 1'b0, addressUpdateFlag);
		u_isa_i2c_ctrl.xfer(lo, ack);
		chk1("lack", 1'b1, ack);
		chk("lbuf", lo, shiftBufferReg);
		chk1("lua", 1'b1, addressUpdateFlag);
		sw(WR | CL | RD, d);
		frame(hb | 8'h01, 1'b1);
		sw(RL | CL | RD, 8'h00);
		u_isa_i2c_ctrl.stop();
		$display("test ten-bit done");
		cfg(isa_pkg::MODE_10BIT_SP, 1'b0, 1'b0);
		frame(hb, 1'b1);
		sw(WR | CL | RD, lo);
		u_isa_i2c_ctrl.xfer(~lo, ack);
		chk1("mack", 1'b0, ack);
		chk1("mhold", 1'b1, sclOe);
		chk1("mirq", 1'b1, portIrqFlag);
		chk1("mua", 1'b1, addressUpdateFlag);
		sw(WR | CL | RD, d);
		u_isa_i2c_ctrl.stop();
		$display("test low mismatch done");
		chk("pins", 8'h00, {6'h00, sclOut, sdaOut});
		wrap_up();
	end
endmodule // tb
